// ---- ebsw_pkg.sv ----
/*
  Package for the external bus strobe and wait controller: register map,
  field positions, reset values, access command carrier and states.
  Assumes one system clock and an APB register port with 32-bit data.
*/
package ebsw_pkg;
  localparam logic [11:0] ADDR_WAIT_HIGH = 12'h000;
  localparam logic [11:0] ADDR_WAIT_B = 12'h004;
  localparam logic [11:0] ADDR_ACCESS_STATE = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;
  localparam int A3_WAIT_LSB = 12;
  localparam int CAS_LSB = 4;
  localparam logic [15:0] WAIT_HIGH_MASK = 16'h7000;
  localparam logic [15:0] WAIT_HIGH_RESET = 16'h7000;
  localparam logic [2:0] CAS_RESET = 3'h7;
  localparam logic [2:0] CAS_MAX_LEGAL = 3'h3;
  localparam logic [7:0] AST_RESET = 8'hff;
  localparam logic [2:0] AREA_SDRAM = 3'h2;
  localparam logic [2:0] AREA_WAIT = 3'h3;
  localparam logic [2:0] CNT_ZERO = 3'h0;

  typedef struct packed {
    logic [2:0] area;
    logic [23:0] addr;
    logic write;
    logic word;
    logic wide;
    logic [15:0] wdata;
  } ebsw_req_t;

  typedef struct packed {
    logic rdStrobe_n;
    logic hwrStrobe_n;
    logic lwrStrobe_n;
    logic upperOe_n;
    logic lowerOe_n;
    logic [15:0] dataOut;
  } ebsw_pins_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_T1 = 5'b00010,
    ST_T2 = 5'b00100,
    ST_WAIT = 5'b01000,
    ST_T3 = 5'b10000
  } ebsw_state_t;
endpackage : ebsw_pkg

// ---- ebsw_lane_dec.sv ----
/*
  Lane decoder: which data halves and write strobes an access uses.
  Assumes a request held stable by the requester for the whole access.
*/
`timescale 1ns/1ns
module ebsw_lane_dec
  import ebsw_pkg::*;
(
  input wire ebsw_req_t req,
  output logic upperUsed,
  output logic lowerUsed
);
  always_comb begin
    if (!req.wide) begin
      upperUsed = 1'b1;
      lowerUsed = 1'b0;
    end else if (!req.word) begin
      upperUsed = ~req.addr[0];
      lowerUsed = req.addr[0];
    end else begin
      upperUsed = 1'b1;
      lowerUsed = 1'b1;
    end
  end
endmodule : ebsw_lane_dec

// ---- ebsw_ctrl.sv ----
/*
  External bus strobe and wait controller: APB registers, access cycle
  sequencer, strobe and lane control, read data capture.
  Assumes requests held until done and bus pins synchronised outside.
*/
`timescale 1ns/1ns
module ebsw_ctrl
  import ebsw_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reqValid,
  input wire ebsw_req_t req,
  output logic reqDone,
  output logic [15:0] readData,
  input wire logic [15:0] dataIn,
  output ebsw_pins_t pins
);
  logic [15:0] areaWaitControlHigh;
  logic [2:0] casLatency;
  logic [7:0] accessStateControlReg;
  ebsw_state_t state;
  ebsw_state_t next_state;
  logic [2:0] waitCnt;
  logic upperUsed;
  logic lowerUsed;
  logic apbWr;
  logic apbRd;
  logic addrHit;

  ebsw_lane_dec u_lane (
    .req(req),
    .upperUsed(upperUsed),
    .lowerUsed(lowerUsed)
  );

  function automatic logic isMapped(input logic [11:0] a);
    return a == ADDR_WAIT_HIGH || a == ADDR_WAIT_B || a == ADDR_ACCESS_STATE ||
      a == ADDR_STATUS;
  endfunction : isMapped

  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && !penable && !pwrite;
  assign addrHit = isMapped(paddr);

  // Area-3 wait field register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      areaWaitControlHigh <= WAIT_HIGH_RESET;
    end else if (apbWr && paddr == ADDR_WAIT_HIGH) begin
      areaWaitControlHigh <= pwdata[15:0] & WAIT_HIGH_MASK;
    end
  end

  // CAS latency field
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      casLatency <= CAS_RESET;
    end else if (apbWr && paddr == ADDR_WAIT_B) begin
      casLatency <= pwdata[CAS_LSB +: 3];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      accessStateControlReg <= AST_RESET;
    end else if (apbWr && paddr == ADDR_ACCESS_STATE) begin
      accessStateControlReg <= pwdata[7:0];
    end
  end

  // Read data registered in setup so access phase answers at once
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (apbRd) begin
      case (paddr)
        ADDR_WAIT_HIGH: prdata <= {16'h0000, areaWaitControlHigh};
        ADDR_WAIT_B: prdata <= {25'h0000000, casLatency, 4'h0};
        ADDR_ACCESS_STATE: prdata <= {24'h000000, accessStateControlReg};
        ADDR_STATUS: prdata <= {27'h0000000, state};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addrHit;
    end
  end

  // Extra states for the current request
  function automatic logic [2:0] extraStates(input ebsw_req_t r, input logic [7:0] ast,
                                             input logic [15:0] wh, input logic [2:0] cas);
    logic [2:0] n;
    n = CNT_ZERO;
    if (r.area == AREA_WAIT && ast[AREA_WAIT])
      n = wh[A3_WAIT_LSB +: 3];
    if (r.area == AREA_SDRAM && cas <= CAS_MAX_LEGAL)
      n = cas;
    return n;
  endfunction : extraStates

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (reqValid) next_state = ST_T1;
      ST_T1: next_state = ST_T2;
      ST_T2: begin
        if (waitCnt != CNT_ZERO) next_state = ST_WAIT;
        else if (accessStateControlReg[req.area]) next_state = ST_T3;
        else next_state = ST_IDLE;
      end
      ST_WAIT: begin
        if (waitCnt != CNT_ZERO) next_state = ST_WAIT;
        else if (accessStateControlReg[req.area]) next_state = ST_T3;
        else next_state = ST_IDLE;
      end
      ST_T3: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) state <= ST_IDLE;
    else state <= next_state;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) waitCnt <= CNT_ZERO;
    else if (state == ST_IDLE && reqValid)
      waitCnt <= extraStates(req, accessStateControlReg, areaWaitControlHigh, casLatency);
    else if ((state == ST_T2 || state == ST_WAIT) && waitCnt != CNT_ZERO)
      waitCnt <= waitCnt - 3'h1;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) reqDone <= 1'b0;
    else reqDone <= (state != ST_IDLE) && (next_state == ST_IDLE);
  end

  // Strobes and lanes; held active through waits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins <= '{rdStrobe_n: 1'b1, hwrStrobe_n: 1'b1, lwrStrobe_n: 1'b1,
                upperOe_n: 1'b1, lowerOe_n: 1'b1, dataOut: 16'h0000};
    end else if (next_state != ST_IDLE && !(state == ST_IDLE && !reqValid)) begin
      pins.rdStrobe_n <= req.write;
      pins.hwrStrobe_n <= !(req.write && upperUsed);
      // low strobe high for 8-bit space
      pins.lwrStrobe_n <= !(req.write && lowerUsed && req.wide);
      pins.upperOe_n <= !(req.write && upperUsed);
      pins.lowerOe_n <= !(req.write && lowerUsed && req.wide);
      pins.dataOut <= req.wide && req.word ? req.wdata :
                      (lowerUsed && req.wide ? {8'h00, req.wdata[7:0]} :
                       {req.wdata[7:0], 8'h00});
    end else begin
      pins.rdStrobe_n <= 1'b1;
      pins.hwrStrobe_n <= 1'b1;
      pins.lwrStrobe_n <= 1'b1;
      pins.upperOe_n <= 1'b1;
      pins.lowerOe_n <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) readData <= 16'h0000;
    else if (!req.write && state != ST_IDLE && next_state == ST_IDLE)
      readData <= {upperUsed ? dataIn[15:8] : 8'h00, (lowerUsed && req.wide) ? dataIn[7:0] : 8'h00};
  end
endmodule : ebsw_ctrl

// ---- ebsw_ctrl_checker.sv ----
/* Port checker for the external bus strobe and wait controller.
   Assumes the requester holds req stable until reqDone. */
`timescale 1ns/1ns
module ebsw_ctrl_checker
  import ebsw_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire ebsw_req_t req,
  input wire logic reqDone,
  input wire ebsw_pins_t pins
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence sSetup;
    psel && !penable;
  endsequence
  chk_apb_answer: assert property (sSetup |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  chk_apb_unmapped: assert property (sSetup and paddr > 12'h00c |=> pslverr)
    else $error("unmapped address without pslverr");
  chk_read_lanes: assert property (
    !pins.rdStrobe_n |-> pins.upperOe_n && pins.lowerOe_n && pins.hwrStrobe_n)
    else $error("read strobe with write strobe or drive");
  chk_narrow_low: assert property (
    !req.wide |-> pins.lwrStrobe_n && pins.lowerOe_n)
    else $error("low half used in 8-bit space");
  chk_odd_upper: assert property (
    req.wide && !req.word && req.addr[0] |-> pins.hwrStrobe_n && pins.upperOe_n)
    else $error("upper half used by odd byte");
  chk_even_lower: assert property (
    req.wide && !req.word && !req.addr[0] |-> pins.lwrStrobe_n && pins.lowerOe_n)
    else $error("lower half used by even byte");
  chk_min_states: assert property ($fell(pins.rdStrobe_n) |=> !pins.rdStrobe_n)
    else $error("read strobe shorter than two states");
  chk_done_edge: assert property (
    reqDone |-> $rose(pins.rdStrobe_n && pins.hwrStrobe_n && pins.lwrStrobe_n))
    else $error("reqDone not at strobe release");
  chk_done_pulse: assert property (reqDone |=> !reqDone)
    else $error("reqDone longer than one cycle");
endmodule : ebsw_ctrl_checker
bind ebsw_ctrl ebsw_ctrl_checker u_ebsw_ctrl_checker (.clk(clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .req(req), .reqDone(reqDone), .pins(pins));

// ---- ebsw_ext_mem.sv ----
/* Model of a 16-bit external memory on the data bus.
   Assumes registered strobes and lane enables from the controller. */
`timescale 1ns/1ns
module ebsw_ext_mem
  import ebsw_pkg::*;
(
  input wire logic clk,
  input wire ebsw_pins_t pins,
  output logic [15:0] dataIn
);
  logic [15:0] mem = 16'h0;
  initial dataIn = 16'h0;
  always @(posedge clk) begin
    if (!pins.hwrStrobe_n) mem[15:8] <= pins.dataOut[15:8];
    if (!pins.lwrStrobe_n) mem[7:0] <= pins.dataOut[7:0];
  end
  // Lines wander off-bus, so stale data never passes for a read
  always @(posedge clk) dataIn <= pins.rdStrobe_n ? ~dataIn : mem;
endmodule : ebsw_ext_mem

// ---- ebsw_ctrl_tb.sv ----
/* Testbench for ebsw_ctrl: APB register tests and external accesses.
   Assumes the memory model answers every read. */
`timescale 1ns/1ns
module ebsw_ctrl_tb
  import ebsw_pkg::*;
;
  logic clk = 0, sysRst = 1, psel = 0, penable = 0, pwrite = 0;
  logic reqValid = 0, pready, pslverr, reqDone;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [15:0] readData, dataIn;
  logic [4:0] sb;
  logic e;
  int len, fail_count = 0, num_checks = 0;
  ebsw_req_t req = '0;
  ebsw_pins_t pins;
  logic [3:0][4:0] lanes = {5'b10000, 5'b11010, 5'b10101, 5'b10101};
  ebsw_ctrl u_ebsw_ctrl (.clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reqValid(reqValid), .req(req), .reqDone(reqDone),
    .readData(readData), .dataIn(dataIn), .pins(pins));
  ebsw_ext_mem u_ebsw_ext_mem (.clk(clk), .pins(pins), .dataIn(dataIn));
  initial forever #5 clk = ~clk;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1;
    // Settled answer looked at mid-cycle; it stands until the next rising edge
    do @(negedge clk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) fail_count++;
    q = prdata;
    e = pslverr;
    @(posedge clk);
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask : apb
  task automatic acc(input logic [2:0] ar, input logic a0, w, wd, wi);
    int n = 0;
    len = 0;
    req <= '{ar, {23'h0, a0}, w, wd, wi, 16'ha55a};
    reqValid <= 1;
    @(posedge clk) reqValid <= 0;
    while (reqDone !== 1'b1 && n++ < 40) begin
      @(negedge clk);
      if (!(pins.rdStrobe_n & pins.hwrStrobe_n & pins.lwrStrobe_n)) begin
        if (len == 0) sb = pins[20:16];
        len++;
      end
    end
    @(posedge clk);
  endtask : acc
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (6) @(posedge clk);
    sysRst <= 0;
    @(posedge clk);
    apb(0, ADDR_WAIT_HIGH, 0); chk("wait_rst", 32'h7000, q);
    apb(0, ADDR_WAIT_B, 0); chk("cas_rst", 32'h70, q & 32'h70);
    apb(1, ADDR_WAIT_HIGH, 32'hffff); apb(0, ADDR_WAIT_HIGH, 0);
    chk("wait_rsvd", 32'h7000, q);
    apb(0, 12'h010, 0); chk("unmapped", 32'h1, {q[30:0], e});
    $display("register test done");
    for (int i = 0; i < 8; i++) begin
      apb(1, ADDR_WAIT_HIGH, i << 12);
      acc(AREA_WAIT, 0, 0, 0, 0); chk("area3_len", 3 + i, len);
    end
    apb(1, ADDR_ACCESS_STATE, 0);
    acc(AREA_WAIT, 0, 0, 0, 0); chk("area3_2st", 2, len);
    for (int c = 0; c < 4; c++) begin
      apb(1, ADDR_WAIT_B, c << 4);
      acc(AREA_SDRAM, 0, 0, 1, 1); chk("cas_len", 2 + c, len);
    end
    apb(0, ADDR_WAIT_B, 0); chk("cas_rd", 32'h30, q & 32'h70);
    $display("wait test done");
    for (int i = 0; i < 4; i++) begin
      acc(3'h0, i == 2, 1, i == 3, i != 0);
      chk("wr_lanes", lanes[i], sb);
    end
    acc(3'h0, 1, 0, 0, 1); chk("rd_lanes", 5'h0f, sb);
    chk("odd_rd", 16'h005a, readData);
    acc(3'h0, 0, 0, 1, 1); chk("word_rd", 16'ha55a, readData);
    $display("lane test done");
    report_and_stop;
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    report_and_stop;
  end
endmodule : ebsw_ctrl_tb
